// ### inc/acc_pkg.sv
package acc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          AW             = 32;
  localparam int          DW             = 32;
  localparam logic [31:0] ADDR_CTRL      = 32'h0000_0f90;
  localparam logic [31:0] ADDR_AUX       = 32'h0000_0f94;
  localparam logic [31:0] ADDR_STAT      = 32'h0000_0f98;
  localparam logic [31:0] ADDR_MASK      = 32'h0000_0f9c;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int          CTRL_W         = 8;
  localparam logic [7:0]  CTRL_RESET     = 8'h14;
  localparam int          POS_SEL_BIT    = 7;
  localparam int          NEG_SEL_BIT    = 6;
  localparam int          REF_HI         = 5;
  localparam int          REF_LO_LARGE   = 2;
  localparam int          REF_LO_SMALL   = 0;

  // ----------------------------------------------------------------------
  // Auxiliary register fields
  // ----------------------------------------------------------------------
  localparam int          AUX_W          = 8;
  localparam logic [7:0]  AUX_RESET      = 8'h00;
  localparam int          AUX_PD_BIT     = 0;
  localparam int          AUX_ROUTE_BIT  = 1;
  localparam int          AUX_PKG_BIT    = 6;
  localparam int          AUX_RESULT_BIT = 7;

  // ----------------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------------
  localparam int          EV_W           = 2;
  localparam int          EV_RISE        = 0;
  localparam int          EV_FALL        = 1;
  localparam logic [1:0]  EV_RESET       = 2'h0;

  // ----------------------------------------------------------------------
  // Analog levels in millivolts
  // ----------------------------------------------------------------------
  localparam int          MV_W           = 12;
  localparam logic [11:0] STEP_LARGE_MV  = 12'h0c8;
  localparam logic [11:0] STEP_SMALL_MV  = 12'h032;
  localparam logic [12:0] HYST_MV        = 13'h000a;

  // ----------------------------------------------------------------------
  // Bus
  // ----------------------------------------------------------------------
  localparam int          HTRANS_ACT_BIT = 1;
  localparam logic        HRESP_OKAY     = 1'b0;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_WAIT,
    ACC_RESP
  } acc_bus_t;

endpackage

// ### rtl/acc_sync.sv
module acc_sync
  import acc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,     // System clock.
  input  wire logic         arst_n,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] d,       // Level from another domain.
  output logic      [W-1:0] q        // Level after two flip-flops.
);

  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // acc_sync

// ### rtl/acc_top.sv
// Contract
// - Result high/low beyond hysteresis margin.
// - Inside hysteresis band, result holds.
// - Result feeds interrupt and routable pin.
// - Bit 7 picks pin or temperature sensor.
// - Bit 6 picks pin or internal reference.
// - Large package: bits 5:2, 0.2 V steps.
// - Small package: bits 5:0, 0.05 V steps.
// - Large package ignores bits 1:0.
// - Reference set only by this register.
// - Powered down comparator holds its result.
module acc_top
  import acc_pkg::*;
(
  input  wire logic            clk,              // System clock.
  input  wire logic            arst_n,           // Async reset, low.
  input  wire logic            hsel,             // Slave select.
  input  wire logic [AW-1:0]   haddr,            // Byte address.
  input  wire logic [1:0]      htrans,           // Transfer type.
  input  wire logic            hwrite,           // Write when high.
  input  wire logic [2:0]      hsize,            // Transfer size.
  input  wire logic            hready,           // Bus ready in.
  input  wire logic [DW-1:0]   hwdata,           // Write data.
  output logic      [DW-1:0]   hrdata,           // Read data.
  output logic                 hreadyout,        // Slave ready.
  output logic                 hresp,            // Always OKAY.
  input  wire logic [MV_W-1:0] pos_input_pin,    // Positive pin, mV.
  input  wire logic [MV_W-1:0] neg_input_pin,    // Negative pin, mV.
  input  wire logic [MV_W-1:0] temp_sense_mv,    // Sensor level, mV.
  input  wire logic            small_package,    // Package strap.
  output logic                 ref_enable,       // Reference on.
  output logic [MV_W-1:0]      ref_level_mv,     // Reference level.
  output logic                 cmp_powered,      // Core powered.
  output logic                 cmp_result,       // Held result.
  output logic                 cmp_pin_out,      // Pin data.
  output logic                 cmp_pin_oe_n,     // Pin enable, low.
  output logic                 irq               // Interrupt level.
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_n;

  acc_sync #(.W(1)) u_rst_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (1'b1),
    .q      (rst_n)
  );

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [CTRL_W-1:0] comparator_control;
  logic [AUX_W-1:0]  aux_control;
  logic [EV_W-1:0]   event_status;
  logic [EV_W-1:0]   event_mask;
  logic              pkg_small;

  // ----------------------------------------------------------------------
  // AHB-Lite slave, one wait state on every transfer
  // ----------------------------------------------------------------------
  acc_bus_t        bus_state;
  acc_bus_t        next_bus_state;
  logic [AW-1:0]   req_addr;
  logic            req_write;
  logic            take;
  logic            wr_ctrl;
  logic            wr_aux;
  logic            wr_stat;
  logic            wr_mask;
  logic [DW-1:0]   next_rdata;

  assign take = hsel && htrans[HTRANS_ACT_BIT] && hready;

  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      ACC_IDLE: begin
        if (take) begin
          next_bus_state = ACC_WAIT;
        end
      end
      ACC_WAIT: begin
        next_bus_state = ACC_RESP;
      end
      ACC_RESP: begin
        if (take) begin
          next_bus_state = ACC_WAIT;
        end else begin
          next_bus_state = ACC_IDLE;
        end
      end
      default: begin
        next_bus_state = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= ACC_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_addr  <= '0;
      req_write <= 1'b0;
    end else if (take && bus_state != ACC_WAIT) begin
      req_addr  <= haddr;
      req_write <= hwrite;
    end
  end

  assign hreadyout = (bus_state != ACC_WAIT);
  assign hresp     = HRESP_OKAY;

  always_comb begin
    wr_ctrl = 1'b0;
    wr_aux  = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (bus_state == ACC_WAIT && req_write) begin
      if (req_addr == ADDR_CTRL) begin
        wr_ctrl = 1'b1;
      end else if (req_addr == ADDR_AUX) begin
        wr_aux = 1'b1;
      end else if (req_addr == ADDR_STAT) begin
        wr_stat = 1'b1;
      end else if (req_addr == ADDR_MASK) begin
        wr_mask = 1'b1;
      end
    end
  end

  always_comb begin
    next_rdata = '0;
    if (req_addr == ADDR_CTRL) begin
      next_rdata = DW'(comparator_control);
    end else if (req_addr == ADDR_AUX) begin
      next_rdata = DW'({cmp_result, pkg_small,
                        aux_control[AUX_PKG_BIT-1:0]});
    end else if (req_addr == ADDR_STAT) begin
      next_rdata = DW'(event_status);
    end else if (req_addr == ADDR_MASK) begin
      next_rdata = DW'(event_mask);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= '0;
    end else if (bus_state == ACC_WAIT && !req_write) begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // The reference follows this register alone; the converter's own
  // reference selection never reaches this block.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      comparator_control <= CTRL_RESET;
    end else if (wr_ctrl) begin
      comparator_control <= hwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_control <= AUX_RESET;
    end else if (wr_aux) begin
      aux_control <= hwdata[AUX_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_mask <= EV_RESET;
    end else if (wr_mask) begin
      event_mask <= hwdata[EV_W-1:0];
    end
  end

  acc_sync #(.W(1)) u_pkg_sync (
    .clk    (clk),
    .arst_n (rst_n),
    .d      (small_package),
    .q      (pkg_small)
  );

  // ----------------------------------------------------------------------
  // Input selection and reference level
  // ----------------------------------------------------------------------
  logic [MV_W-1:0] pos_mv;
  logic [MV_W-1:0] neg_mv;
  logic [MV_W-1:0] ref_mv;

  always_comb begin
    if (pkg_small) begin
      ref_mv = MV_W'(comparator_control[REF_HI:REF_LO_SMALL])
               * STEP_SMALL_MV;
    end else begin
      ref_mv = MV_W'(comparator_control[REF_HI:REF_LO_LARGE])
               * STEP_LARGE_MV;
    end
  end

  assign pos_mv = comparator_control[POS_SEL_BIT] ? temp_sense_mv
                : pos_input_pin;
  assign neg_mv = comparator_control[NEG_SEL_BIT] ? ref_mv
                : neg_input_pin;

  assign ref_enable   = comparator_control[NEG_SEL_BIT];
  assign ref_level_mv = ref_mv;
  assign cmp_powered  = !aux_control[AUX_PD_BIT];

  // ----------------------------------------------------------------------
  // Comparator core and result synchroniser
  // ----------------------------------------------------------------------
  logic [1:0] core_dec;
  logic [1:0] sync_dec;
  logic       above_s;
  logic       below_s;

  // The core decides on its own timing; its two decisions are treated as
  // asynchronous and cross into the bus logic through two flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_dec <= '0;
    end else begin
      core_dec[1] <= {1'b0, pos_mv} > {1'b0, neg_mv} + HYST_MV;
      core_dec[0] <= {1'b0, neg_mv} > {1'b0, pos_mv} + HYST_MV;
    end
  end

  acc_sync #(.W(2)) u_dec_sync (
    .clk    (clk),
    .arst_n (rst_n),
    .d      (core_dec),
    .q      (sync_dec)
  );

  assign above_s = sync_dec[1];
  assign below_s = sync_dec[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_result <= 1'b0;
    end else if (cmp_powered) begin
      if (above_s) begin
        cmp_result <= 1'b1;
      end else if (below_s) begin
        cmp_result <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin route and interrupt
  // ----------------------------------------------------------------------
  logic       result_d;
  logic [1:0] ev_set;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_d     <= 1'b0;
      cmp_pin_out  <= 1'b0;
      cmp_pin_oe_n <= 1'b1;
    end else begin
      result_d     <= cmp_result;
      cmp_pin_out  <= cmp_result;
      cmp_pin_oe_n <= !aux_control[AUX_ROUTE_BIT];
    end
  end

  assign ev_set[EV_RISE] = cmp_result && !result_d;
  assign ev_set[EV_FALL] = !cmp_result && result_d;

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_status <= EV_RESET;
    end else begin
      event_status <= (event_status & ~({EV_W{wr_stat}}
                      & hwdata[EV_W-1:0])) | ev_set;
    end
  end

  assign irq = |(event_status & event_mask);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  result_rise_a: assert property (
    cmp_powered && above_s |=> cmp_result)
    else $error("result did not rise above the band");

  result_fall_a: assert property (
    cmp_powered && !above_s && below_s |=> !cmp_result)
    else $error("result did not fall below the band");

  band_hold_a: assert property (
    !above_s && !below_s |=> $stable(cmp_result))
    else $error("result moved inside the band");

  power_hold_a: assert property (
    !cmp_powered |=> $stable(cmp_result))
    else $error("result moved while powered down");

  sync_delay_a: assert property (
    ##2 1'b1 |-> sync_dec == $past(core_dec, 2))
    else $error("decision not delayed by two stages");

  irq_rise_a: assert property (
    $rose(cmp_result) |=> event_status[EV_RISE]
    && (irq || !event_mask[EV_RISE]))
    else $error("rising result gave no interrupt");

  pin_follow_a: assert property (
    ##1 1'b1 |-> cmp_pin_out == $past(cmp_result))
    else $error("pin does not follow result");

  pos_select_a: assert property (
    comparator_control[POS_SEL_BIT] |-> pos_mv == temp_sense_mv)
    else $error("sensor not on positive input");

  neg_select_a: assert property (
    !comparator_control[NEG_SEL_BIT] |-> neg_mv == neg_input_pin
    && !ref_enable)
    else $error("pin not on negative input");

  large_ref_a: assert property (
    !pkg_small |-> ref_mv == MV_W'(comparator_control[REF_HI:REF_LO_LARGE])
    * STEP_LARGE_MV)
    else $error("large package reference wrong");

  small_ref_a: assert property (
    pkg_small |-> ref_mv == MV_W'(comparator_control[REF_HI:REF_LO_SMALL])
    * STEP_SMALL_MV)
    else $error("small package reference wrong");

  low_bits_a: assert property (
    !pkg_small && $stable(comparator_control[REF_HI:REF_LO_LARGE])
    && $stable(pkg_small) |-> $stable(ref_mv))
    else $error("reserved bits moved the reference");

  ctrl_write_a: assert property (
    !wr_ctrl |=> $stable(comparator_control))
    else $error("control changed without a write");

  set_wins_a: assert property (
    ev_set[EV_RISE] |=> event_status[EV_RISE])
    else $error("event lost against clear");

  rise_c: cover property ($rose(cmp_result));
  fall_c: cover property ($fell(cmp_result));
  irq_c:  cover property ($rose(irq));
  pd_c:   cover property (!cmp_powered && below_s);

endmodule // acc_top

// ### tb/acc_analog_model.sv
module acc_analog_model
  import acc_pkg::*;
(
  input  wire logic            clk,            // System clock.
  input  wire logic            slow,           // Extra settling stage.
  input  wire logic [MV_W-1:0] pos_set,        // Wanted positive level.
  input  wire logic [MV_W-1:0] neg_set,        // Wanted negative level.
  input  wire logic [MV_W-1:0] tmp_set,        // Wanted sensor level.
  output logic      [MV_W-1:0] pos_input_pin,  // Positive pin, mV.
  output logic      [MV_W-1:0] neg_input_pin,  // Negative pin, mV.
  output logic      [MV_W-1:0] temp_sense_mv   // Sensor level, mV.
);
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------------------------------------------
  // Analog sources
  // --------------------------------------------------------------------
  // Levels move on the clock; a slow source settles one cycle later.
  logic [3*MV_W-1:0] lag_q;

  always_ff @(posedge clk) begin
    lag_q <= {pos_set, neg_set, tmp_set};
    {pos_input_pin, neg_input_pin, temp_sense_mv} <=
      slow ? lag_q : {pos_set, neg_set, tmp_set};
  end
endmodule // acc_analog_model

// ### tb/acc_top_tb_top.sv
module acc_top_tb_top
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic            clk = 1'b0;
  logic            arst_n = 1'b0;
  logic            hsel = 1'b0;
  logic            hwrite = 1'b0;
  logic            small_package = 1'b0;
  logic            slow = 1'b0;
  logic            rd_phase = 1'b0;
  logic [1:0]      htrans = 2'h0;
  logic [AW-1:0]   haddr = '0;
  logic [DW-1:0]   hwdata = '0;
  logic [DW-1:0]   hrdata;
  logic            hreadyout;
  logic            hresp;
  logic            ref_enable;
  logic            cmp_powered;
  logic            cmp_result;
  logic            cmp_pin_out;
  logic            cmp_pin_oe_n;
  logic            irq;
  logic [MV_W-1:0] ref_level_mv;
  logic [MV_W-1:0] pos_set = '0;
  logic [MV_W-1:0] neg_set = '0;
  logic [MV_W-1:0] tmp_set = '0;
  logic [MV_W-1:0] pos_pin;
  logic [MV_W-1:0] neg_pin;
  logic [MV_W-1:0] tmp_pin;
  logic [DW-1:0]   v;
  logic [DW-1:0]   rd_q[$];
  int              errors = 0;
  int              cmp_count = 0;
  int              seed = 32'h716f;
  int              sc[4] = '{0, 1, 20, 36};

  always #5 clk = ~clk;

  acc_top acc_top_i (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pos_input_pin(pos_pin), .neg_input_pin(neg_pin),
    .temp_sense_mv(tmp_pin), .small_package(small_package),
    .ref_enable(ref_enable), .ref_level_mv(ref_level_mv),
    .cmp_powered(cmp_powered), .cmp_result(cmp_result),
    .cmp_pin_out(cmp_pin_out), .cmp_pin_oe_n(cmp_pin_oe_n), .irq(irq)
  );

  acc_analog_model acc_analog_model_i (
    .clk(clk), .slow(slow), .pos_set(pos_set), .neg_set(neg_set),
    .tmp_set(tmp_set), .pos_input_pin(pos_pin),
    .neg_input_pin(neg_pin), .temp_sense_mv(tmp_pin)
  );

  // --------------------------------------------------------------------
  // Checking and reporting
  // --------------------------------------------------------------------
  task automatic tally_and_finish;
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data is taken at the edge that completes the transfer.
  always @(posedge clk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      chk(hrdata, rd_q.pop_front());
    end
  end

  // --------------------------------------------------------------------
  // Bus master
  // --------------------------------------------------------------------
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      errors++;
      $display("BAD %0t bus never ready", $time);
      tally_and_finish();
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    rd_phase <= !w;
    if (!w) begin
      rd_q.push_back(d);
    end
    wait_rdy();
    rd_phase <= 1'b0;
  endtask

  // --------------------------------------------------------------------
  // Comparator helpers
  // --------------------------------------------------------------------
  task automatic ana(input int p, input int n, input int t);
    pos_set <= MV_W'(p);
    neg_set <= MV_W'(n);
    tmp_set <= MV_W'(t);
  endtask

  task automatic wait_res(input logic e);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cmp_result !== e && n < 12);
    chk(cmp_result, e);
    @(posedge clk);
  endtask

  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(ref_level_mv, 32'd1000);
    chk(ref_enable, 32'h0);
    chk(hresp, 32'h0);
    chk(cmp_pin_oe_n, 32'h1);
    bus(1'b0, ADDR_CTRL, 32'h14);
    bus(1'b1, 32'h0, 32'hff);
    bus(1'b0, 32'h0, 32'h0);
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, ADDR_CTRL, {k[3:0], 2'h3} | 32'h40);
      chk(ref_level_mv, 32'(k * 200));
      chk(ref_enable, 32'h1);
    end
    for (int i = 0; i < 4; i++) begin
      v = {24'h0, 8'($random(seed))};
      bus(1'b1, ADDR_CTRL, v);
      bus(1'b0, ADDR_CTRL, v);
    end
    small_package <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_CTRL, 32'(sc[i]));
      chk(ref_level_mv, 32'(sc[i] * 50));
    end
    small_package <= 1'b0;
    repeat (3) @(posedge clk);
    bus(1'b1, ADDR_MASK, 32'h3);
    bus(1'b1, ADDR_CTRL, 32'h54);
    ana(1020, 0, 0);
    wait_res(1'b1);
    ana(1005, 0, 0);
    settle();
    chk(cmp_result, 32'h1);
    ana(980, 0, 0);
    wait_res(1'b0);
    ana(995, 0, 0);
    settle();
    chk(cmp_result, 32'h0);
    chk(irq, 32'h1);
    bus(1'b0, ADDR_STAT, 32'h3);
    bus(1'b1, ADDR_MASK, 32'h0);
    chk(irq, 32'h0);
    bus(1'b1, ADDR_STAT, 32'h1);
    bus(1'b0, ADDR_STAT, 32'h2);
    bus(1'b1, ADDR_STAT, 32'h2);
    bus(1'b1, ADDR_MASK, 32'h3);
    chk(irq, 32'h0);
    bus(1'b1, ADDR_MASK, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h94);
    settle();
    bus(1'b1, ADDR_STAT, 32'h3);
    bus(1'b1, ADDR_MASK, 32'h3);
    chk(irq, 32'h0);
    bus(1'b1, ADDR_AUX, 32'h2);
    slow <= 1'b1;
    ana(0, 500, 800);
    wait_res(1'b1);
    settle();
    chk(cmp_pin_out, 32'h1);
    chk(irq, 32'h1);
    chk(cmp_pin_oe_n, 32'h0);
    bus(1'b1, ADDR_AUX, 32'h3);
    chk(cmp_powered, 32'h0);
    ana(2000, 500, 400);
    settle();
    chk(cmp_result, 32'h1);
    bus(1'b1, ADDR_AUX, 32'h2);
    wait_res(1'b0);
    bus(1'b0, ADDR_AUX, 32'h2);
    tally_and_finish();
  end
endmodule // acc_top_tb_top
